/* File: inc/sdl_consts.svh */
// constants of the serial dac load interface
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH
`define SDL_WORD_BITS 16
`define SDL_CNT_BITS 5
`define SDL_FIFO_DEPTH 4
`define SDL_CLK_PERIOD_PS 5000
`define SDL_LOAD_MIN_NS 100
`define SDL_WORD_ZERO 16'h0000
`define SDL_CNT_ZERO 5'h00
`define SDL_CNT_ONE 5'h01
`define SDL_PIN_RESET 4'h3
`endif

/* File: inc/sdl_pkg.sv */
// types of the serial dac load interface
`default_nettype none
package sdl_pkg;
  typedef logic [15:0] sdl_word_t;
  // frame tracking states, gray coded
  typedef enum logic [1:0] {
    SDL_IDLE = 2'b00,
    SDL_SHIFT = 2'b01,
    SDL_DONE = 2'b11
  } sdl_state_e;
endpackage
`default_nettype wire

/* File: inc/sdl_stream_if.sv */
// word stream carrier from the shifter into the fifo and from the fifo to the latch
`default_nettype none
interface sdl_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hdl/sdl_fifo.sv */
// small word fifo with valid/ready on both sides
`default_nettype none
module sdl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  sdl_stream_if.snk in_s,
  // drain side
  sdl_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign in_s.ready = (cnt_q != DEPTH[AW:0]);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem[rd_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: hdl/sdl_top.sv */
// serial load interface of a 16-bit dac, device side
`default_nettype none
`include "sdl_consts.svh"

// ****************************************
// serial dac load interface
// ****************************************
module sdl_top
  import sdl_pkg::*;
#(
  parameter int WORD_BITS = `SDL_WORD_BITS,
  parameter int FIFO_DEPTH = `SDL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // serial link pins
  input wire logic SER_CLK,
  input wire logic SER_DATA_IN,
  input wire logic FRAME_SYNC_N,
  input wire logic LATCH_LOAD_N,
  input wire logic CHAIN_ENABLE,
  output logic CHAIN_DATA_OUT,
  // dac latch side
  output logic [WORD_BITS-1:0] DAC_LATCH,
  output logic DAC_UPDATE,
  output logic FRAME_ACTIVE
);
  // shortest strobe the device is sure to see, in ref clock cycles
  localparam int LOAD_MIN_CYC = (`SDL_LOAD_MIN_NS * 1000) / `SDL_CLK_PERIOD_PS;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sclk_old_q;
  logic load_old_q;
  logic sclk_fall;
  logic load_fall;
  logic sync_n;
  logic ser_data_in;
  logic chain_en;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      // strobe bit resets low: a strobe held low gives no false edge
      meta_q <= `SDL_PIN_RESET;
      sync_q <= `SDL_PIN_RESET;
    end else begin
      meta_q <= {SER_DATA_IN, LATCH_LOAD_N, FRAME_SYNC_N, SER_CLK};
      sync_q <= meta_q;
    end
  end

  // edge history of serial clock and load strobe
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sclk_old_q <= 1'b1;
      load_old_q <= 1'b0;
    end else begin
      sclk_old_q <= sync_q[0];
      load_old_q <= sync_q[2];
    end
  end

  // chain enable is a strap, two flops like the rest
  logic chain_meta_q;
  logic chain_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      chain_meta_q <= 1'b0;
      chain_q <= 1'b0;
    end else begin
      chain_meta_q <= CHAIN_ENABLE;
      chain_q <= chain_meta_q;
    end
  end

  assign sync_n = sync_q[1];
  assign ser_data_in = sync_q[3];
  assign chain_en = chain_q;
  assign sclk_fall = sclk_old_q && !sync_q[0];
  // falling strobe edge; strobe glitches shorter than one ref clock cycle may be lost
  assign load_fall = load_old_q && !sync_q[2];

  // ****************************************
  // frame tracking and shifter
  // ****************************************
  sdl_state_e state_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [`SDL_CNT_BITS-1:0] cnt_q;
  logic word_done;
  logic take_bit;

  // a bit is only taken while the frame is open
  assign take_bit = sclk_fall && !sync_n;
  assign word_done = take_bit && (cnt_q == `SDL_CNT_BITS'(WORD_BITS - 1));

  // frame state follows sync; after sixteen bits stay in done until sync rises, chained or not
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_q <= SDL_IDLE;
    end else begin
      case (state_q)
        SDL_IDLE: begin
          if (!sync_n) begin
            state_q <= SDL_SHIFT;
          end
        end
        SDL_SHIFT: begin
          if (sync_n) begin
            state_q <= SDL_IDLE;
          end else if (word_done) begin
            state_q <= SDL_DONE;
          end
        end
        SDL_DONE: begin
          if (sync_n) begin
            state_q <= SDL_IDLE;
          end
        end
        default: begin
          state_q <= SDL_IDLE;
        end
      endcase
    end
  end

  // bit counter wraps per word so chained frames count each word
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cnt_q <= `SDL_CNT_ZERO;
    end else if (sync_n) begin
      cnt_q <= `SDL_CNT_ZERO;
    end else if (take_bit) begin
      cnt_q <= word_done ? `SDL_CNT_ZERO : cnt_q + `SDL_CNT_ONE;
    end
  end

  // shift toward msb, new bit at lsb; msb first on the wire
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      shift_q <= `SDL_WORD_ZERO;
    end else if (take_bit && (state_q != SDL_DONE || chain_en)) begin
      shift_q <= {shift_q[WORD_BITS-2:0], ser_data_in};
    end
  end

  // chained data ripples out of the top of the register
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CHAIN_DATA_OUT <= 1'b0;
    end else if (chain_en) begin
      CHAIN_DATA_OUT <= shift_q[WORD_BITS-1];
    end else begin
      CHAIN_DATA_OUT <= 1'b0;
    end
  end

  // ****************************************
  // word fifo toward the dac latch
  // ****************************************
  sdl_stream_if #(.WIDTH(WORD_BITS)) fill_s ();
  sdl_stream_if #(.WIDTH(WORD_BITS)) drain_s ();
  logic auto_req;
  logic auto_take;
  logic strobe_req_q;
  logic pend_q;
  logic stage_ready;

  // automatic mode: latch strobe low throughout, word pushed at 16th edge
  // a long frame must not push a second word once the first is done
  assign auto_req = word_done && !sync_q[2] && !chain_en && (state_q != SDL_DONE);
  assign fill_s.valid = auto_req;
  assign fill_s.data = {shift_q[WORD_BITS-2:0], ser_data_in};
  assign auto_take = auto_req && fill_s.ready;

  // strobe mode: falling strobe marks the held word pending; a non-empty fifo keeps it pending
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pend_q <= 1'b0;
    end else if (load_fall && !auto_req) begin
      pend_q <= 1'b1;
    end else if (pend_q && stage_ready) begin
      pend_q <= 1'b0;
    end
  end

  // a second path into the latch: the strobe path bypasses the fifo but waits until it is empty
  assign stage_ready = !drain_s.valid;

  sdl_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // latch drains one word per cycle; strobe updates win only when fifo empty
  assign drain_s.ready = 1'b1;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      DAC_LATCH <= `SDL_WORD_ZERO;
      DAC_UPDATE <= 1'b0;
      strobe_req_q <= 1'b0;
    end else begin
      strobe_req_q <= 1'b0;
      DAC_UPDATE <= 1'b0;
      if (drain_s.valid) begin
        DAC_LATCH <= drain_s.data;
        DAC_UPDATE <= 1'b1;
      end else if (pend_q) begin
        DAC_LATCH <= shift_q;
        DAC_UPDATE <= 1'b1;
        strobe_req_q <= 1'b1;
      end
    end
  end

  // frame indicator for the user side
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      FRAME_ACTIVE <= 1'b0;
    end else begin
      FRAME_ACTIVE <= (state_q != SDL_IDLE);
    end
  end

  // strobe shorter than this many cycles is not guaranteed to be seen
  logic unused_ok;
  assign unused_ok = auto_take | strobe_req_q | (LOAD_MIN_CYC == 0);
endmodule
`default_nettype wire

/* File: test/sdl_top_sva.sv */
// checker on the pins of the dac load interface
`default_nettype none
module sdl_top_sva #(parameter int WORD_BITS = 16) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // link and latch
  input wire logic FRAME_SYNC_N,
  input wire logic LATCH_LOAD_N,
  input wire logic CHAIN_ENABLE,
  input wire logic CHAIN_DATA_OUT,
  input wire logic [WORD_BITS-1:0] DAC_LATCH,
  input wire logic DAC_UPDATE,
  input wire logic FRAME_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // one clock domain for all
  // ***
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_pulse; DAC_UPDATE |=> !DAC_UPDATE; endproperty
  a_pulse: assert property (p_pulse) else $error("long update");
  property p_hold; !DAC_UPDATE |-> $stable(DAC_LATCH); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_strobe; $fell(LATCH_LOAD_N) && FRAME_SYNC_N |-> ##[3:8] DAC_UPDATE; endproperty
  a_strobe: assert property (p_strobe) else $error("no strobe update");
  property p_wait; LATCH_LOAD_N [*8] |-> !DAC_UPDATE; endproperty
  a_wait: assert property (p_wait) else $error("update with strobe high");
  property p_off; !CHAIN_ENABLE [*4] |-> !CHAIN_DATA_OUT; endproperty
  a_off: assert property (p_off) else $error("chain out while off");
  property p_still; (FRAME_SYNC_N && CHAIN_ENABLE) [*8] |-> $stable(CHAIN_DATA_OUT); endproperty
  a_still: assert property (p_still) else $error("shift outside frame");
  property p_idle; FRAME_SYNC_N [*8] |-> !FRAME_ACTIVE; endproperty
  a_idle: assert property (p_idle) else $error("frame after sync high");
  property p_act; !FRAME_SYNC_N [*8] |-> FRAME_ACTIVE; endproperty
  a_act: assert property (p_act) else $error("frame not tracked");
endmodule
bind sdl_top sdl_top_sva #(.WORD_BITS(WORD_BITS)) i_sva (.REF_CLK(REF_CLK), .RST(RST),
  .FRAME_SYNC_N(FRAME_SYNC_N), .LATCH_LOAD_N(LATCH_LOAD_N), .CHAIN_ENABLE(CHAIN_ENABLE),
  .CHAIN_DATA_OUT(CHAIN_DATA_OUT), .DAC_LATCH(DAC_LATCH), .DAC_UPDATE(DAC_UPDATE),
  .FRAME_ACTIVE(FRAME_ACTIVE));
`default_nettype wire

/* File: test/sdl_host_model.sv */
// host serial port driving the link
`default_nettype none
module sdl_host_model (
  // clock
  input wire logic clk,
  // link
  input wire logic chain_out,
  output logic sclk,
  output logic sdat,
  output logic sync_n,
  output logic load_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic obs [64];
  // ***
  // serial clock and sync idle high, data and strobe low
  // ***
  initial begin
    sclk = 1'b1;
    sdat = 1'b0;
    sync_n = 1'b1;
    load_n = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // strobe held at level v for n cycles of 5 ns
  task automatic set_load(input logic v, input int n);
    load_n <= v;
    hold(n);
  endtask
  // 16 cycles a phase gives 80 ns; gap pauses between bytes
  task automatic send(input logic [63:0] w, input int n, input logic gap, input logic frame);
    sync_n <= !frame;
    hold(16);
    for (int i = n - 1; i >= 0; i--) begin
      if (gap && i == 7) hold(100);
      sdat <= w[i];
      hold(16);
      obs[n-1-i] = chain_out;
      sclk <= 1'b0;
      hold(16);
      sclk <= 1'b1;
    end
    hold(16);
    sync_n <= 1'b1;
    sdat <= ~sdat; // released line must not look stable
    hold(16);
  endtask
endmodule
`default_nettype wire

/* File: test/sdl_top_tb.sv */
// self-checking bench of the dac load interface
`default_nettype none
module sdl_top_tb import sdl_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chain_en = 1'b0;
  logic sclk, sdat, sync_n, load_n, cout, upd, act;
  sdl_word_t latch;
  sdl_word_t exp_q [$];
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  initial forever #2.5 clk = ~clk;
  sdl_top i_dut (.REF_CLK(clk), .RST(rst), .SER_CLK(sclk), .SER_DATA_IN(sdat),
    .FRAME_SYNC_N(sync_n), .LATCH_LOAD_N(load_n), .CHAIN_ENABLE(chain_en),
    .CHAIN_DATA_OUT(cout), .DAC_LATCH(latch), .DAC_UPDATE(upd), .FRAME_ACTIVE(act));
  sdl_host_model i_host (.clk(clk), .chain_out(cout), .sclk(sclk), .sdat(sdat),
    .sync_n(sync_n), .load_n(load_n));
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ***
  // result watcher and hang limit
  // ***
  always @(negedge clk) begin
    cyc++;
    if (upd === 1'b1 && exp_q.size() == 0) check("surplus update", 16'h0000, 16'h0001);
    else if (upd === 1'b1) check("latch", exp_q.pop_front(), latch);
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end
  // ***
  // main sequence
  // ***
  initial begin
    sdl_word_t w [4];
    void'($urandom(73));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    i_host.hold(4);
    // automatic mode, back to back, second word in two bytes
    for (int k = 0; k < 3; k++) begin
      w[k] = $urandom();
      exp_q.push_back(w[k]);
      i_host.send(w[k], 16, k == 1, 1'b1);
    end
    // bits past sixteen are dropped, clocks without sync ignored
    w[0] = $urandom();
    exp_q.push_back(w[0]);
    i_host.send({w[0], 4'h9}, 20, 1'b0, 1'b1);
    i_host.send(16'hffff, 16, 1'b0, 1'b0);
    // strobe controlled update
    i_host.set_load(1'b1, 16);
    w[0] = $urandom();
    i_host.send(w[0], 16, 1'b0, 1'b1);
    i_host.hold(40);
    exp_q.push_back(w[0]);
    i_host.set_load(1'b0, 20);
    i_host.set_load(1'b1, 16);
    // four words through the chain, then one common strobe
    chain_en <= 1'b1;
    i_host.hold(16);
    for (int k = 0; k < 4; k++) w[k] = $urandom();
    i_host.send({w[0], w[1], w[2], w[3]}, 64, 1'b0, 1'b1);
    for (int i = 16; i < 64; i++) check("chain out", w[(i-16)/16][15-(i%16)], i_host.obs[i]);
    exp_q.push_back(w[3]);
    i_host.set_load(1'b0, 20);
    chain_en <= 1'b0;
    i_host.set_load(1'b1, 16);
    check("chain off", 16'h0000, cout);
    check("pending", 16'h0000, exp_q.size());
    conclude();
  end
endmodule
`default_nettype wire
